/* File: rtl/positioning_chain_sequencer.sv */
`timescale 1ns/1ps

module positioning_chain_sequencer
  import chain_seq_pkg::*;
#(
  parameter int TICK_CYCLES = DWELL_TICK_CYCLES
)
(
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  // pins from the host controller
  input  wire logic [ENTRY_W-1:0]   entry_select_inputs_i,
  input  wire logic                 start_i,
  input  wire logic                 alarm_clr_i,
  // operation data table load port
  input  wire logic                 cfg_we_i,
  input  wire logic [ENTRY_W-1:0]   cfg_idx_i,
  input  wire logic [FUNC_W-1:0]    cfg_func_i,
  input  wire logic                 cfg_dir_i,
  input  wire logic [DWELL_W-1:0]   cfg_dwell_i,
  // motion profile generator handshake
  input  wire logic                 seg_done_i,
  output logic                      seg_start_o,
  output logic [ENTRY_W-1:0]        seg_entry_o,
  output logic [ENTRY_W-1:0]        seg_accel_entry_o,
  output logic                      seg_link_o,
  output logic                      seg_push_start_o,
  // status pins
  output logic                      ready_o,
  output logic                      move_o,
  output logic                      op_data_alarm_o,
  output logic [ENTRY_W-1:0]        active_entry_o
);

  logic [FUNC_W-1:0]   func_mem  [ENTRY_COUNT];
  logic                dir_mem   [ENTRY_COUNT];
  logic [DWELL_W-1:0]  dwell_mem [ENTRY_COUNT];

  logic [ENTRY_W-1:0]     sel_s1_q;
  logic [ENTRY_W-1:0]     sel_s2_q;
  logic                   start_s1_q;
  logic                   start_s2_q;
  logic                   start_s3_q;
  logic                   start_rise;

  seq_state_t             state_q;
  logic [ENTRY_W-1:0]     cur_q;
  logic [ENTRY_W-1:0]     scan_idx_q;
  logic [CHAIN_CNT_W-1:0] scan_cnt_q;
  logic [DWELL_W-1:0]     dwell_left_q;
  logic [TICK_W-1:0]      tick_q;

  logic                   seg_start_q;
  logic [ENTRY_W-1:0]     seg_entry_q;
  logic [ENTRY_W-1:0]     seg_accel_q;
  logic                   seg_link_q;
  logic                   seg_push_q;
  logic                   ready_q;
  logic                   move_q;
  logic                   alarm_q;

  logic [ENTRY_W-1:0]     nxt;
  logic [FUNC_W-1:0]      cur_func;
  logic [FUNC_W-1:0]      nxt_func;
  logic [FUNC_W-1:0]      scan_func;
  logic                   cur_at_last;
  logic                   nxt_links;
  logic                   scan_links;
  logic                   dir_clash;
  logic                   tick_wrap;
  logic                   alarm_set;
  logic                   alarm_clear;

  // two-flop synchronisers for the select and start pins; third start flop only for the edge
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      sel_s1_q   <= '0;
      sel_s2_q   <= '0;
      start_s1_q <= 1'b0;
      start_s2_q <= 1'b0;
      start_s3_q <= 1'b0;
    end
    else
    begin
      sel_s1_q   <= entry_select_inputs_i;
      sel_s2_q   <= sel_s1_q;
      start_s1_q <= start_i;
      start_s2_q <= start_s1_q;
      start_s3_q <= start_s2_q;
    end
  end

  assign start_rise = start_s2_q & ~start_s3_q;

  // operation data table, 64 entries addressed 0 to 63
  always_ff @(posedge core_clk_i)
  begin
    if (cfg_we_i)
    begin
      func_mem[cfg_idx_i]  <= cfg_func_i;
      dir_mem[cfg_idx_i]   <= cfg_dir_i;
      dwell_mem[cfg_idx_i] <= cfg_dwell_i;
    end
  end

  assign nxt         = cur_q + ENTRY_STEP;
  assign cur_func    = func_mem[cur_q];
  assign nxt_func    = func_mem[nxt];
  assign scan_func   = func_mem[scan_idx_q];
  assign cur_at_last = (cur_q == ENTRY_LAST);
  // entry 63 is processed alone whatever its function says
  assign nxt_links   = (nxt_func == FUNC_LINK) && (nxt != ENTRY_LAST);
  assign scan_links  = ((scan_func == FUNC_LINK) || (scan_func == FUNC_LINK2))
                       && (scan_idx_q != ENTRY_LAST);
  assign dir_clash   = (dir_mem[nxt] != dir_mem[cur_q]);
  assign tick_wrap   = (tick_q == TICK_W'(TICK_CYCLES - 1));
  // overlong chain found by the scan, or a reversal across a linked-motion join
  assign alarm_set   = ((state_q == ST_SCAN) && scan_links && (scan_cnt_q == CHAIN_MAX))
                       || ((state_q == ST_RUN) && seg_done_i && (cur_func == FUNC_LINK) && !cur_at_last
                           && dir_clash);
  assign alarm_clear = (state_q == ST_FAULT) && alarm_clr_i;

  // dwell timebase: one tick per dwell unit
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      tick_q <= TICK_ZERO;
    end
    else if (state_q != ST_DWELL || tick_wrap)
    begin
      tick_q <= TICK_ZERO;
    end
    else
    begin
      tick_q <= tick_q + TICK_STEP;
    end
  end

  // operation-data alarm flag; a new error wins over a clear in the same cycle
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      alarm_q <= 1'b0;
    end
    else if (alarm_set)
    begin
      alarm_q <= 1'b1;
    end
    else if (alarm_clear)
    begin
      alarm_q <= 1'b0;
    end
  end

  // sequencer
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state_q      <= ST_IDLE;
      cur_q        <= '0;
      scan_idx_q   <= '0;
      scan_cnt_q   <= '0;
      dwell_left_q <= DWELL_ZERO;
      seg_start_q  <= 1'b0;
      seg_entry_q  <= '0;
      seg_accel_q  <= '0;
      seg_link_q   <= 1'b0;
      seg_push_q   <= 1'b0;
      ready_q      <= 1'b1;
      move_q       <= 1'b0;
    end
    else
    begin
      seg_start_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (start_rise && ready_q)
          begin
            cur_q      <= sel_s2_q;
            scan_idx_q <= sel_s2_q;
            scan_cnt_q <= CHAIN_FIRST;
            ready_q    <= 1'b0;
            state_q    <= ST_SCAN;
          end
        end

        ST_SCAN:
        begin
          // walk the chain before moving so an overlong one never starts
          if (scan_links)
          begin
            if (scan_cnt_q == CHAIN_MAX)
            begin
              state_q <= ST_FAULT;
            end
            else
            begin
              scan_idx_q <= scan_idx_q + ENTRY_STEP;
              scan_cnt_q <= scan_cnt_q + CHAIN_FIRST;
            end
          end
          else
          begin
            move_q      <= 1'b1;
            seg_start_q <= 1'b1;
            seg_entry_q <= cur_q;
            seg_accel_q <= cur_q;
            seg_link_q  <= (cur_func == FUNC_LINK) && !cur_at_last;
            seg_push_q  <= 1'b0;
            state_q     <= ST_RUN;
          end
        end

        ST_RUN:
        begin
          if (seg_done_i)
          begin
            if (cur_func == FUNC_LINK && !cur_at_last)
            begin
              if (dir_clash)
              begin
                move_q  <= 1'b0;
                state_q <= ST_FAULT;
              end
              else
              begin
                cur_q       <= nxt;
                seg_start_q <= 1'b1;
                seg_entry_q <= nxt;
                seg_link_q  <= nxt_links;
                seg_push_q  <= (nxt_func == FUNC_PUSH);
              end
            end
            else if (cur_func == FUNC_LINK2 && !cur_at_last)
            begin
              move_q       <= 1'b0;
              dwell_left_q <= dwell_mem[cur_q];
              state_q      <= ST_DWELL;
            end
            else
            begin
              // single-motion, push, or entry 63: chain ends here
              move_q  <= 1'b0;
              ready_q <= 1'b1;
              state_q <= ST_IDLE;
            end
          end
        end

        ST_DWELL:
        begin
          if (dwell_left_q == DWELL_ZERO)
          begin
            // restart from standstill; direction may reverse here
            cur_q       <= nxt;
            move_q      <= 1'b1;
            seg_start_q <= 1'b1;
            seg_entry_q <= nxt;
            seg_accel_q <= nxt;
            seg_link_q  <= nxt_links;
            seg_push_q  <= 1'b0;
            state_q     <= ST_RUN;
          end
          else if (tick_wrap)
          begin
            dwell_left_q <= dwell_left_q - DWELL_STEP;
          end
        end

        ST_FAULT:
        begin
          move_q <= 1'b0;
          // ready stays low until the alarm is cleared
          if (alarm_clr_i)
          begin
            ready_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end

        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign seg_start_o       = seg_start_q;
  assign seg_entry_o       = seg_entry_q;
  assign seg_accel_entry_o = seg_accel_q;
  assign seg_link_o        = seg_link_q;
  assign seg_push_start_o  = seg_push_q;
  assign ready_o           = ready_q;
  assign move_o            = move_q;
  assign op_data_alarm_o   = alarm_q;
  assign active_entry_o    = cur_q;

endmodule

/* File: rtl/chain_seq_pkg.sv */
package chain_seq_pkg;

  localparam int                ENTRY_W           = 6;
  localparam int                ENTRY_COUNT       = 64;
  localparam logic [5:0]        ENTRY_LAST        = 6'h3f;
  localparam logic [5:0]        ENTRY_STEP        = 6'h01;

  localparam int                FUNC_W            = 2;
  localparam logic [1:0]        FUNC_SINGLE       = 2'h0;
  localparam logic [1:0]        FUNC_LINK         = 2'h1;
  localparam logic [1:0]        FUNC_LINK2        = 2'h2;
  localparam logic [1:0]        FUNC_PUSH         = 2'h3;

  localparam int                CHAIN_CNT_W       = 3;
  localparam logic [2:0]        CHAIN_FIRST       = 3'h1;
  localparam logic [2:0]        CHAIN_MAX         = 3'h4;

  localparam int                DWELL_W           = 16;
  localparam logic [15:0]       DWELL_ZERO        = 16'h0000;
  localparam logic [15:0]       DWELL_STEP        = 16'h0001;

  localparam int                CLK_PERIOD_NS     = 5;
  localparam int                DWELL_UNIT_NS     = 1000000;
  localparam int                DWELL_TICK_CYCLES = DWELL_UNIT_NS / CLK_PERIOD_NS;
  localparam int                TICK_W            = 18;
  localparam logic [17:0]       TICK_ZERO         = 18'h00000;
  localparam logic [17:0]       TICK_STEP         = 18'h00001;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SCAN,
    ST_RUN,
    ST_DWELL,
    ST_FAULT
  } seq_state_t;

endpackage

/* File: verification/chain_seq_properties.sv */
`timescale 1ns/1ps
module chain_seq_checker
  import chain_seq_pkg::*;
(
  input wire logic               core_clk_i,
  input wire logic               rst_i,
  input wire logic               alarm_clr_i,
  input wire logic               seg_done_i,
  input wire logic               seg_start_o,
  input wire logic [ENTRY_W-1:0] seg_entry_o,
  input wire logic [ENTRY_W-1:0] seg_accel_entry_o,
  input wire logic               seg_link_o,
  input wire logic               ready_o,
  input wire logic               move_o,
  input wire logic               op_data_alarm_o
);
  default clocking dc @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence link_done;
    seg_done_i && move_o && seg_link_o;
  endsequence

  chk_idle_still: assert property (ready_o |-> !move_o && !seg_start_o)
    else $error("motion while ready");
  chk_seg_moves: assert property (seg_start_o |-> move_o)
    else $error("segment without move");
  chk_scan_bound: assert property ($fell(ready_o) |-> ##[1:6] (move_o || op_data_alarm_o))
    else $error("no move after start");
  chk_alarm_hold: assert property (op_data_alarm_o && !alarm_clr_i |=> op_data_alarm_o)
    else $error("alarm dropped");
  chk_alarm_clear: assert property (op_data_alarm_o && alarm_clr_i |=> !op_data_alarm_o && ready_o)
    else $error("alarm not cleared");
  chk_alarm_halt: assert property (op_data_alarm_o |-> !move_o && !seg_start_o)
    else $error("motion during alarm");
  chk_link_next: assert property (link_done |=> op_data_alarm_o ||
    seg_start_o && seg_entry_o == $past(seg_entry_o) + ENTRY_STEP) else $error("link did not continue");
  chk_link_accel: assert property (link_done |=> op_data_alarm_o || $stable(seg_accel_entry_o))
    else $error("accel entry changed in link");
  chk_stop_drop: assert property (seg_done_i && move_o && !seg_link_o |=> !move_o)
    else $error("move kept after final segment");

  cover property (link_done);
  cover property ($rose(op_data_alarm_o));
  cover property (seg_done_i && !seg_link_o ##1 !move_o && !ready_o);
endmodule

bind positioning_chain_sequencer chain_seq_checker i_chain_seq_checker (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .alarm_clr_i(alarm_clr_i), .seg_done_i(seg_done_i),
  .seg_start_o(seg_start_o), .seg_entry_o(seg_entry_o), .seg_accel_entry_o(seg_accel_entry_o),
  .seg_link_o(seg_link_o), .ready_o(ready_o), .move_o(move_o), .op_data_alarm_o(op_data_alarm_o));

/* File: verification/far_side_model.sv */
`timescale 1ns/1ps
module far_side_model
  import chain_seq_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               go_i,
  input  wire logic               eager_i,
  input  wire logic [ENTRY_W-1:0] entry_i,
  input  wire logic [31:0]        dly_i,
  input  wire logic               ready_i,
  input  wire logic               seg_start_i,
  output logic [ENTRY_W-1:0]      sel_o = 6'h00,
  output logic                    start_o = 1'h0,
  output logic                    seg_done_o = 1'h0
);
  // host pins; eager skips the ready handshake on purpose
  always @(posedge clk_i)
    if (go_i)
    begin
      while (!ready_i && !eager_i) @(posedge clk_i);
      sel_o <= entry_i;
      repeat (3) @(posedge clk_i);
      start_o <= 1'h1;
      repeat (4) @(posedge clk_i);
      while (ready_i) @(posedge clk_i);
      start_o <= 1'h0;
    end

  // profile generator: one done pulse per segment
  always @(posedge clk_i)
    if (seg_start_i)
    begin
      repeat (dly_i) @(posedge clk_i);
      seg_done_o <= 1'h1;
      @(posedge clk_i);
      seg_done_o <= 1'h0;
    end
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import chain_seq_pkg::*;
;
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, e); end end
  logic        clk = 1'h0, rst = 1'h1, clr = 1'h0, we = 1'h0, dir = 1'h0, go = 1'h0, eager = 1'h0;
  logic [5:0]  ent = 6'h00, idx = 6'h00, sel, s_ent, s_acc, act;
  logic [1:0]  func = 2'h0;
  logic [15:0] dwell = 16'h0000;
  logic        start, done, s_go, s_lnk, s_psh, ready, move, alarm, xa, s;
  logic [1:0]  fn [64];
  logic        dr [64];
  int          dw [64], dly = 1, gap = 0, miscompares = 0, comparisons = 0, i;
  logic [29:0] q [$], x;

  always #2.5 clk = ~clk;

  positioning_chain_sequencer #(.TICK_CYCLES(4)) i_positioning_chain_sequencer (
    .core_clk_i(clk), .rst_i(rst), .entry_select_inputs_i(sel), .start_i(start), .alarm_clr_i(clr),
    .cfg_we_i(we), .cfg_idx_i(idx), .cfg_func_i(func), .cfg_dir_i(dir), .cfg_dwell_i(dwell),
    .seg_done_i(done), .seg_start_o(s_go), .seg_entry_o(s_ent), .seg_accel_entry_o(s_acc), .seg_link_o(s_lnk),
    .seg_push_start_o(s_psh), .ready_o(ready), .move_o(move), .op_data_alarm_o(alarm), .active_entry_o(act));
  far_side_model i_far_side_model (.clk_i(clk), .go_i(go), .eager_i(eager), .entry_i(ent), .dly_i(dly),
    .ready_i(ready), .seg_start_i(s_go), .sel_o(sel), .start_o(start), .seg_done_o(done));

  // each segment start is matched against the next predicted one
  always @(negedge clk)
  begin
    if (s_go)
    begin
      x = q.size() ? q.pop_front() : 30'hx;
      `CHK({act, s_psh, s_lnk, s_acc, s_ent}, {x[5:0], x[13:0]})
      if (x[29:14] != 0)
        `CHK(gap >= x[29:14] * 4 && gap <= x[29:14] * 4 + 2, 1'h1)
    end
    gap = move ? 0 : gap + 1;
  end

  task automatic wr(input int k, input logic [1:0] f, input logic d, input int w);
    fn[k] = f;
    dr[k] = d;
    dw[k] = w;
    @(posedge clk);
    idx <= k[5:0];
    func <= f;
    dir <= d;
    dwell <= w[15:0];
    we <= 1'h1;
    @(posedge clk);
    we <= 1'h0;
  endtask

  task automatic predict(input int e);
    int k, a, d, n;
    n = 0;
    while (fn[e + n] inside {FUNC_LINK, FUNC_LINK2} && e + n != 63)
      n++;
    xa = n >= 4;
    a = e;
    d = 0;
    for (k = e; !xa; k++)
    begin
      q.push_back({d[15:0], k != e && fn[k] == FUNC_PUSH && fn[k - 1] == FUNC_LINK,
                   fn[k] == FUNC_LINK && k != 63, a[5:0], k[5:0]});
      if (fn[k] inside {FUNC_SINGLE, FUNC_PUSH} || k == 63)
        break;
      xa = fn[k] == FUNC_LINK && dr[k] != dr[k + 1];
      d = fn[k] == FUNC_LINK2 ? dw[k] : 0;
      a = fn[k] == FUNC_LINK2 ? k + 1 : a;
    end
  endtask

  task automatic run(input int e, input logic eg);
    int t;
    predict(e);
    dly <= eg ? 40 : $urandom_range(1, 6);
    ent <= e[5:0];
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    for (t = 0; t < 20 && ready; t++) @(posedge clk);
    `CHK(ready, 1'h0)
    if (eg)
    begin
      repeat (4) @(posedge clk);
      eager <= 1'h1;
      go <= 1'h1;
      @(posedge clk);
      go <= 1'h0;
    end
    for (t = 0; t < 2000 && !ready && !alarm; t++) @(posedge clk);
    `CHK(t < 2000, 1'h1)
    `CHK(alarm, xa)
    `CHK(q.size(), 0)
    clr <= alarm;
    repeat (2) @(posedge clk);
    clr <= 1'h0;
    eager <= 1'h0;
    `CHK({ready, move}, 2'h2)
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    miscompares++;
    tally_and_finish();
  end

  initial
  begin
    s = 1'($urandom(32'hb9d5));
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    for (i = 0; i < 64; i++)
      wr(i, FUNC_SINGLE, 1'($urandom), 0);
    run($urandom_range(0, 9), 1'h0);
    for (i = 10; i < 13; i++)
      wr(i, FUNC_LINK, s, 0);
    wr(13, FUNC_SINGLE, s, 0);
    run(10, 1'h0);
    wr(20, FUNC_LINK, s, 0);
    wr(21, FUNC_PUSH, s, 0);
    run(20, 1'h0);
    wr(30, FUNC_LINK2, s, 3);
    wr(31, FUNC_SINGLE, !s, 0);
    run(30, 1'h0);
    wr(63, FUNC_LINK2, s, 2);
    run(63, 1'h0);
    for (i = 40; i < 45; i++)
      wr(i, FUNC_LINK, s, 0);
    run(40, 1'h0);
    wr(50, FUNC_LINK, s, 0);
    wr(51, FUNC_SINGLE, !s, 0);
    run(50, 1'h0);
    run(5, 1'h1);
    tally_and_finish();
  end
endmodule
